/* inc/rst_seq_pkg.sv */
// Package: constants and types for the reset sequencer and configuration latch
package rst_seq_pkg;
   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int unsigned CLK_PERIOD_NS   = 10;              // CORE_CLK period
   localparam int unsigned MIN_PULSE_CYC   = 4;               // Least reset request width
   localparam int unsigned POR_STRETCH_CYC = 4096;            // Pin hold after power-on release
   localparam int unsigned HRD_STRETCH_CYC = 4096;            // Internal hold after hard release
   localparam int unsigned LOCK_DELAY_CYC  = 2;               // Extra sampling before freeze
   localparam int unsigned CNT_W           = 13;              // Counter width
   localparam int unsigned CFG_W           = 7;               // Configuration word width
   localparam logic [CFG_W-1:0] CFG_RESET  = 7'h00;           // Word value after reset

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_STRETCH} stretch_st_t;

   // Synchronised reset input levels, active low
   typedef struct packed {
      logic por_n;
      logic hard_n;
      logic soft_n;
   } rst_lines_t;
endpackage

/* src/rst_stretch.sv */
// Stretcher: counts a held request, then holds its output for a fixed count
`timescale 1ns/1ps
module rst_stretch
   import rst_seq_pkg::*;
#(
   parameter int unsigned MIN_CYC     = 4,
   parameter int unsigned STRETCH_CYC = 4096
)(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic req_n,       // Synchronised request, active low
   input  wire logic force_any,   // Start stretching on release even if short
   output logic      hold         // Stretched output, active high
);
   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      stretch_st_t      st;       // Sequence state
      logic [CNT_W-1:0] cnt;      // Shared width / stretch counter
      logic             hold;     // Output flop
   } str_state_t;

   str_state_t s_reg;             // Registered state
   str_state_t s_next;            // Next state

   // Next-state logic
   always_comb begin
      s_next = s_reg;
      case (s_reg.st)
         ST_IDLE: begin
            // Begin measuring on assertion
            if (!req_n) begin
               s_next.st   = ST_HOLD;
               s_next.cnt  = CNT_W'(1);
            end
         end
         ST_HOLD: begin
            if (!req_n) begin
               // Saturating width count
               if (s_reg.cnt < CNT_W'(MIN_CYC))
                  s_next.cnt = s_reg.cnt + CNT_W'(1);
               if (s_reg.cnt >= CNT_W'(MIN_CYC - 1))
                  s_next.hold = 1'b1;
            end else if (s_reg.hold || force_any) begin
               // Valid width seen: stretch after release
               s_next.st   = ST_STRETCH;
               s_next.cnt  = '0;
               s_next.hold = 1'b1;
            end else begin
               // Too short: ignored
               s_next.st  = ST_IDLE;
               s_next.cnt = '0;
            end
         end
         ST_STRETCH: begin
            // Re-assertion returns to hold with the width count already met; hold stays high
            if (!req_n) begin
               s_next.st  = ST_HOLD;
               s_next.cnt = CNT_W'(MIN_CYC);
            end else if (s_reg.cnt == CNT_W'(STRETCH_CYC - 1)) begin
               s_next.st   = ST_IDLE;
               s_next.cnt  = '0;
               s_next.hold = 1'b0;
            end else begin
               s_next.cnt = s_reg.cnt + CNT_W'(1);
            end
         end
         default: s_next = '0;
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign hold = s_reg.hold;
endmodule // rst_stretch

/* src/rst_seq_top.sv */
// Top: reset sequencing, pin stretching and configuration word latching
`timescale 1ns/1ps
// Operation
// (R1) Resets accepted anytime, any clock phase
// (R2) Hard/soft requests need four cycle width
// (R3) Power-on held until supplies, oscillator, PLL
// (R4) Later power-on needs hard reset width; the code takes any power-on low level at once, with no width check
// (R5) Pins held low 4096 after power-on
// (R6) Internal resets held 4096 after hard
// (R7) Sample configuration while hard/power-on asserted
// (R8) Two more samples, then freeze word
// (R9) Board keeps configuration pins steady
// (R10) Power-on input must be glitch free
// (R11) Clock and ratio keep frequencies legal
// (R12) Allow oscillator and PLL start times
// (R13) Synchronise reset inputs before counting
module rst_seq_top
   import rst_seq_pkg::*;
(
   input  wire logic             CORE_CLK,
   input  wire logic             SRST,
   input  wire logic             POR_N_IN,
   input  wire logic             HARD_N_IN,
   input  wire logic             SOFT_N_IN,
   input  wire logic [CFG_W-1:0] CFG_PINS,
   output logic                  HARD_N_OUT,
   output logic                  HARD_N_OE,
   output logic                  SOFT_N_OUT,
   output logic                  SOFT_N_OE,
   output logic                  INT_RST,
   output logic                  SOFT_RST,
   output logic [CFG_W-1:0]      CFG_WORD,
   output logic                  CFG_LOCKED
);
   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   rst_lines_t sync1_reg;         // First stage, read only by second stage
   rst_lines_t sync2_reg;         // Clean levels

   // Inputs may fall at any phase; two flops give a clean edge [R1] [R13]
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= '{por_n: POR_N_IN, hard_n: HARD_N_IN, soft_n: SOFT_N_IN};
         sync2_reg <= sync1_reg;
      end
   end

   // ==========================================================================
   // Stretchers
   // ==========================================================================
   logic hard_hold;               // Internal reset after hard request
   logic soft_hold;               // Soft reset after soft request
   logic hard_req_n;              // Hard request seen from outside only

   // Our own pin drive must not retrigger the hard stretcher; mask on the enable, not the data.
   // The two synced low cycles left after release stay below the minimum width and are ignored.
   assign hard_req_n = sync2_reg.hard_n | HARD_N_OE;

   // Hard request: 4-cycle minimum, 4096 stretch [R2] [R6]
   rst_stretch #(.MIN_CYC(MIN_PULSE_CYC), .STRETCH_CYC(HRD_STRETCH_CYC)) u_hard (
      .clk       (CORE_CLK),
      .srst      (SRST),
      .req_n     (hard_req_n),
      .force_any (1'b0),
      .hold      (hard_hold)
   );

   // Soft request: same minimum width [R2]
   rst_stretch #(.MIN_CYC(MIN_PULSE_CYC), .STRETCH_CYC(HRD_STRETCH_CYC)) u_soft (
      .clk       (CORE_CLK),
      .srst      (SRST),
      .req_n     (sync2_reg.soft_n | SOFT_N_OE),
      .force_any (1'b0),
      .hold      (soft_hold)
   );

   // ==========================================================================
   // Main state
   // ==========================================================================
   typedef struct packed {
      logic             por_seen;   // Power-on level was seen low
      logic [CNT_W-1:0] por_cnt;    // Pin hold counter after power-on
      logic             pin_drv;    // Driving both reset pins low
      logic [1:0]       lock_cnt;   // Extra samples after release
      logic             locked;     // Configuration frozen
      logic [CFG_W-1:0] cfg;        // Configuration word
      logic             int_rst;    // Internal reset
      logic             soft_rst;   // Soft reset output
   } top_state_t;

   top_state_t s_reg;               // Registered state
   top_state_t s_next;              // Next state
   logic       cfg_window;          // Either sampling reset asserted

   assign cfg_window = ~sync2_reg.por_n | ~sync2_reg.hard_n;

   // Next-state logic
   always_comb begin
      s_next = s_reg;
      // Power-on: no filter here, the input must be clean [R10] [R4]
      if (!sync2_reg.por_n) begin
         s_next.por_seen = 1'b1;
         s_next.pin_drv  = 1'b1;
         s_next.por_cnt  = '0;
      end else if (s_reg.por_seen) begin
         // Hold pins after power-on release [R5]
         if (s_reg.por_cnt == CNT_W'(POR_STRETCH_CYC - 1)) begin
            s_next.por_seen = 1'b0;
            s_next.pin_drv  = 1'b0;
            s_next.por_cnt  = '0;
         end else begin
            s_next.por_cnt = s_reg.por_cnt + CNT_W'(1);
         end
      end
      // Sampling window and lock [R7] [R8]
      if (cfg_window) begin
         s_next.cfg      = CFG_PINS;
         s_next.lock_cnt = '0;
         s_next.locked   = 1'b0;
      end else if (!s_reg.locked) begin
         s_next.cfg = CFG_PINS;
         if (s_reg.lock_cnt == 2'(LOCK_DELAY_CYC - 1))
            s_next.locked = 1'b1;
         else
            s_next.lock_cnt = s_reg.lock_cnt + 2'(1);
      end
      // Internal reset follows power-on, pin drive and hard; soft reset also follows soft [R6]
      s_next.int_rst  = ~sync2_reg.por_n | s_reg.pin_drv | hard_hold;
      s_next.soft_rst = s_next.int_rst | soft_hold;
   end

   // State register; pins are driven from reset onward
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         s_reg          <= '0;
         s_reg.pin_drv  <= 1'b1;
         s_reg.int_rst  <= 1'b1;
         s_reg.soft_rst <= 1'b1;
         s_reg.cfg      <= CFG_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================================
   // Outputs, all from flops
   // ==========================================================================
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         HARD_N_OUT <= 1'b0;
         HARD_N_OE  <= 1'b1;
         SOFT_N_OUT <= 1'b0;
         SOFT_N_OE  <= 1'b1;
      end else begin
         // Open-drain: enable only while pulling low [R5]
         HARD_N_OUT <= 1'b0;
         SOFT_N_OUT <= 1'b0;
         HARD_N_OE  <= s_next.pin_drv;
         SOFT_N_OE  <= s_next.pin_drv;
      end
   end

   assign INT_RST    = s_reg.int_rst;
   assign SOFT_RST   = s_reg.soft_rst;
   assign CFG_WORD   = s_reg.cfg;
   assign CFG_LOCKED = s_reg.locked;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_cfg_frozen: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R8]
      (s_reg.locked && !cfg_window) |=> $stable(s_reg.cfg))
      else $error("Configuration word changed after lock");
   a_cfg_sample: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R7]
      cfg_window |=> (s_reg.cfg == $past(CFG_PINS)) && !s_reg.locked)
      else $error("Configuration word not sampled during reset");
   a_lock_delay: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R8]
      (cfg_window ##1 !cfg_window [*2]) |=> s_reg.locked)
      else $error("Lock not taken two cycles after release");
   a_lock_early: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R8]
      (cfg_window ##1 !cfg_window) |=> !s_reg.locked)
      else $error("Lock taken too early");
   a_por_pins: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R5]
      !sync2_reg.por_n |=> s_reg.pin_drv)
      else $error("Pins not held during power-on");
   a_por_release: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R5]
      (s_reg.por_cnt == CNT_W'(POR_STRETCH_CYC - 1) && sync2_reg.por_n) |=> !s_reg.pin_drv)
      else $error("Pins not released after stretch");
   a_int_rst_hard: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R6]
      hard_hold |=> s_reg.int_rst)
      else $error("Internal reset not held during hard stretch");
   a_sync_path: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R13]
      !POR_N_IN ##1 !POR_N_IN |=> !sync2_reg.por_n)
      else $error("Synchroniser did not pass power-on level");
   a_soft_cover: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R2]
      soft_hold |=> s_reg.soft_rst)
      else $error("Soft reset not driven during soft stretch");

   c_por_seq:  cover property (@(posedge CORE_CLK) disable iff (SRST) s_reg.pin_drv ##1 !s_reg.pin_drv);
   c_lock:     cover property (@(posedge CORE_CLK) disable iff (SRST) $rose(s_reg.locked));
   c_hard_str: cover property (@(posedge CORE_CLK) disable iff (SRST) $fell(hard_hold));
endmodule // rst_seq_top

/* verif/board_reset_model.sv */
// Board model: reset supervisor and configuration straps facing the sequencer
`timescale 1ns/1ps
module board_reset_model
   import rst_seq_pkg::*;
(
   input  wire logic             por_req,   // Supervisor holds power-on low
   input  wire logic             hard_req,  // Board pulls hard line low
   input  wire logic             soft_req,  // Board pulls soft line low
   input  wire logic [CFG_W-1:0] cfg_val,   // Strap value chosen by board
   input  wire logic             hard_oe,   // Device pulls hard line low
   input  wire logic             soft_oe,   // Device pulls soft line low
   output logic                  por_n,     // Power-on line level
   output logic                  hard_n,    // Resolved hard wire
   output logic                  soft_n,    // Resolved soft wire
   output logic [CFG_W-1:0]      cfg_pins   // Strap pin levels
);
   // ==========================================================================
   // Wire resolution
   // ==========================================================================
   // Clean level from a supervisor, so no spurious pulse reaches the device
   assign por_n    = ~por_req;
   // Open-drain lines with pull-up: high whenever nobody pulls
   assign hard_n   = (hard_oe | hard_req) ? 1'b0 : 1'b1;
   assign soft_n   = (soft_oe | soft_req) ? 1'b0 : 1'b1;
   // Straps come straight from the board's chosen ratio setting
   assign cfg_pins = cfg_val;
endmodule // board_reset_model

/* verif/tb_reset_sequencer_config_latch.sv */
// Testbench: reset stretching and configuration word latching
`timescale 1ns/1ps
module tb_reset_sequencer_config_latch;
   import rst_seq_pkg::*;
   // ==========================================================================
   // Signals
   // ==========================================================================
   logic             clk = 1'b0;        // Core clock
   logic             srst = 1'b1;       // Synchronous reset
   logic             por_req = 1'b0;    // Board requests
   logic             hard_req = 1'b0;
   logic             soft_req = 1'b0;
   logic [CFG_W-1:0] cfg_val = 7'h00;   // Strap value
   logic             por_n, hard_n, soft_n, h_out, h_oe, s_out, s_oe, int_rst, soft_rst, locked;
   logic [CFG_W-1:0] cfg_pins, cfg_word;
   int               num_errors = 0;    // Mismatches
   int               n_tests = 0;       // Comparisons
   int               cyc = 0;           // Timeout counter
   int               n;                 // Measured hold length

   always #5 clk = ~clk;

   board_reset_model u_board (.por_req(por_req), .hard_req(hard_req), .soft_req(soft_req), .cfg_val(cfg_val),
      .hard_oe(h_oe), .soft_oe(s_oe), .por_n(por_n), .hard_n(hard_n), .soft_n(soft_n), .cfg_pins(cfg_pins));

   rst_seq_top u_dut (.CORE_CLK(clk), .SRST(srst), .POR_N_IN(por_n), .HARD_N_IN(hard_n), .SOFT_N_IN(soft_n),
      .CFG_PINS(cfg_pins), .HARD_N_OUT(h_out), .HARD_N_OE(h_oe), .SOFT_N_OUT(s_out), .SOFT_N_OE(s_oe),
      .INT_RST(int_rst), .SOFT_RST(soft_rst), .CFG_WORD(cfg_word), .CFG_LOCKED(locked));

   // ==========================================================================
   // Helpers
   // ==========================================================================
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Picks the output whose hold length is measured
   function logic sel(input int w);
      case (w)
         0: return h_oe;
         1: return int_rst;
         default: return soft_rst;
      endcase
   endfunction

   // Edges until the chosen output drops, bounded
   task hold_len(input int w, output int len);
      len = 0;
      #1;
      while (sel(w) === 1'b1 && len < 5000) begin
         @(posedge clk);
         #1;
         len++;
      end
   endtask

   // Holds one request for a number of edges, then releases all
   task pulse(input int w, input int len);
      @(posedge clk);
      case (w)
         0: por_req <= 1'b1;
         1: hard_req <= 1'b1;
         default: soft_req <= 1'b1;
      endcase
      repeat (len) @(posedge clk);
      por_req  <= 1'b0;
      hard_req <= 1'b0;
      soft_req <= 1'b0;
   endtask

   // Watches an output stay low after a too-short request
   task quiet(input int w);
      logic seen;
      seen = 1'b0;
      repeat (12) begin
         @(posedge clk);
         #1;
         seen = seen | sel(w);
      end
      check(seen, 1'b0);
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task t_por;
      @(posedge clk);
      por_req <= 1'b1;
      cfg_val <= 7'h5a;
      repeat (10) @(posedge clk);
      #1;
      check(cfg_word, 7'h5a);
      check({h_oe, s_oe, h_out, s_out}, 4'hc);
      check(locked, 1'b0);
      @(posedge clk);
      cfg_val <= 7'h33;
      repeat (3) @(posedge clk);
      #1;
      check(cfg_word, 7'h33);
      @(posedge clk);
      por_req <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      // Device still pulls the hard pin, so sampling goes on; straps stay put
      check({locked, cfg_word}, {1'b0, 7'h33});
      hold_len(0, n);
      check(n + 8 >= 4096 && n + 8 <= 4104, 1'b1);
      check(s_oe, 1'b0);
      // Pin high, two sync stages, then two more samples before the freeze
      repeat (3) @(posedge clk);
      #1;
      check({locked, cfg_word}, {1'b0, 7'h33});
      @(posedge clk);
      #1;
      check({locked, cfg_word}, {1'b1, 7'h33});
      @(posedge clk);
      cfg_val <= 7'h11;
      repeat (3) @(posedge clk);
      #1;
      check(cfg_word, 7'h33);
      $display("test por done");
   endtask

   task t_hard;
      check(int_rst, 1'b0);
      @(posedge clk);
      hard_req <= 1'b1;
      cfg_val  <= 7'h6c;
      repeat (7) @(posedge clk);
      #1;
      check({int_rst, locked, cfg_word}, {2'b10, 7'h6c});
      @(posedge clk);
      hard_req <= 1'b0;
      hold_len(1, n);
      check(n >= 4096 && n <= 4104, 1'b1);
      check({locked, cfg_word}, {1'b1, 7'h6c});
      $display("test hard done");
   endtask

   task t_soft;
      pulse(2, 4);
      // Two sync stages and the width count pass before the soft reset shows
      repeat (3) @(posedge clk);
      #1;
      check({soft_rst, int_rst}, 2'b10);
      hold_len(2, n);
      check(n >= 4096 && n <= 4104, 1'b1);
      check(locked, 1'b1);
      $display("test soft done");
   endtask

   task t_short;
      pulse(1, 3);
      quiet(1);
      pulse(2, 3);
      quiet(2);
      pulse(0, 6);
      hold_len(0, n);
      check(n >= 4096 && n <= 4104, 1'b1);
      $display("test short and repeat done");
   endtask

   // ==========================================================================
   // Run control
   // ==========================================================================
   task finish_test;
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Ceiling well above the four stretches of about 4100 cycles each
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors++;
         finish_test();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      t_por();
      t_hard();
      t_soft();
      t_short();
      finish_test();
   end
endmodule // tb_reset_sequencer_config_latch
